// ==== hw/comm_debug_pkg.sv ====
package comm_debug_pkg;

    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 32;
    localparam int REG_WIDTH = 8;

    // register indexes; byte address is four times the index
    localparam logic [ADDR_WIDTH-1:0] DEBUG_UNLOCK_KEY_INDEX = 16'h0700;
    localparam logic [ADDR_WIDTH-1:0] UART_OVERRIDE_CONTROL_INDEX = 16'h0701;
    localparam logic [ADDR_WIDTH-1:0] DAISY_PORT_OVERRIDE_INDEX = 16'h0702;
    localparam logic [ADDR_WIDTH-1:0] PORT_DRIVER_STATUS_INDEX = 16'h0780;
    localparam logic [ADDR_WIDTH-1:0] UART_COMMAND_ERRORS_INDEX = 16'h0781;
    localparam logic [ADDR_WIDTH-1:0] EVENT_STATUS_INDEX = 16'h0790;
    localparam logic [ADDR_WIDTH-1:0] EVENT_ENABLE_INDEX = 16'h0791;
    localparam logic [ADDR_WIDTH-1:0] EVENT_CLEAR_INDEX = 16'h0792;

    localparam logic [REG_WIDTH-1:0] UNLOCK_CODE = 8'hA5;

    localparam logic [REG_WIDTH-1:0] DEBUG_UNLOCK_KEY_RESET = 8'h00;
    localparam logic [REG_WIDTH-1:0] UART_OVERRIDE_CONTROL_RESET = 8'h04;
    localparam logic [REG_WIDTH-1:0] DAISY_PORT_OVERRIDE_RESET = 8'h0F;
    localparam logic [REG_WIDTH-1:0] EVENT_ENABLE_RESET = 8'h00;

    // uart_override_control fields
    localparam int USER_DAISY_EN_BIT = 0;
    localparam int USER_UART_EN_BIT = 1;
    localparam int UART_TX_EN_BIT = 2;
    localparam int UART_MIRROR_EN_BIT = 3;
    localparam int UART_BAUD_BIT = 4;

    // port enable nibble, daisy_port_override[3:0] and port_driver_status[3:0]
    localparam int PORT_FIELD_LSB = 0;
    localparam int PORT_FIELD_WIDTH = 4;
    localparam logic [3:0] PORT_BASE_RESET = 4'h3;
    localparam logic [3:0] PORT_STACK_RESET = 4'hF;
    localparam int CHAIN_AUTO_DRIVEN_BIT = 4;
    localparam int SERIAL_AUTO_DRIVEN_BIT = 5;

    localparam int ERROR_COUNT = 6;

    typedef struct packed {
        logic lower_tx_enable;
        logic lower_rx_enable;
        logic upper_tx_enable;
        logic upper_rx_enable;
    } port_enable_type;

    // bit order matches uart_command_errors[5:0]
    typedef struct packed {
        logic init_byte_error;
        logic read_while_tx_off;
        logic early_clear_error;
        logic frame_byte_error;
        logic unexpected_command;
        logic command_crc_error;
    } command_error_type;

    // decoded events from the uart command receiver, one-cycle pulses
    typedef struct packed {
        logic byte_valid;
        logic is_init_byte;
        logic stop_error;
        logic frame_type_bad;
        logic reserved_bit_set;
        logic byte_error;
        logic is_read_command;
        logic is_stack_or_broadcast;
        logic frame_end;
        logic crc_bad;
        logic comm_clear;
    } uart_rx_event_type;

endpackage

// ==== hw/comm_debug_override_status.sv ====
`timescale 1ns/1ps
module comm_debug_override_status (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [comm_debug_pkg::ADDR_WIDTH-1:0] i_paddr,
    input wire logic [comm_debug_pkg::DATA_WIDTH-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [comm_debug_pkg::DATA_WIDTH-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_stacked_role,
    input wire logic i_shared_bus_mode,
    input wire comm_debug_pkg::port_enable_type i_auto_port_enable,
    input wire logic i_fault_reset,
    input wire comm_debug_pkg::uart_rx_event_type i_rx_event,
    output comm_debug_pkg::port_enable_type o_port_enable,
    output logic o_uart_tx_enable,
    output logic o_uart_mirror_enable,
    output logic o_uart_baud_slow,
    output logic o_frame_valid,
    output logic o_frame_discard,
    output logic o_irq
);
    import comm_debug_pkg::*;

    logic [REG_WIDTH-1:0] debug_unlock_key;
    logic [REG_WIDTH-1:0] uart_override_control;
    logic [REG_WIDTH-1:0] daisy_port_override;
    command_error_type uart_command_errors;
    logic [ERROR_COUNT-1:0] event_status;
    logic [ERROR_COUNT-1:0] event_enable;
    logic serial_auto_driven;
    logic chain_auto_driven;
    logic ignoring;
    logic in_frame;

    logic unlocked;
    logic serial_user;
    logic daisy_user;
    logic next_uart_tx_enable;
    port_enable_type next_port_enable;
    command_error_type error_event;
    logic setup_phase;
    logic access_done;
    logic write_done;
    logic [ADDR_WIDTH-1:0] word_index;
    logic addr_mapped;
    logic [REG_WIDTH-1:0] next_read_value;
    logic frame_accepted;

    // override decoding
    assign unlocked = (debug_unlock_key == UNLOCK_CODE);
    assign serial_user = unlocked && uart_override_control[USER_UART_EN_BIT];
    assign daisy_user = unlocked && uart_override_control[USER_DAISY_EN_BIT];

    always_comb begin
        // stacked device keeps its transmitter off unless software turns it on
        next_uart_tx_enable = !i_stacked_role;
        if (serial_user) begin
            next_uart_tx_enable = uart_override_control[UART_TX_EN_BIT];
        end
    end

    always_comb begin
        next_port_enable = i_auto_port_enable;
        if (daisy_user) begin
            next_port_enable = port_enable_type'(
                daisy_port_override[PORT_FIELD_LSB +: PORT_FIELD_WIDTH]);
        end
    end

    // effective port controls, registered
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_port_enable <= i_stacked_role ? port_enable_type'(PORT_STACK_RESET)
                                            : port_enable_type'(PORT_BASE_RESET);
            o_uart_tx_enable <= !i_stacked_role;
            o_uart_mirror_enable <= 1'b0;
            o_uart_baud_slow <= 1'b0;
            serial_auto_driven <= 1'b1;
            chain_auto_driven <= 1'b1;
        end else if (i_clk_en) begin
            o_port_enable <= next_port_enable;
            o_uart_tx_enable <= next_uart_tx_enable;
            // mirroring needs the transmitter switched on as well
            o_uart_mirror_enable <= serial_user && uart_override_control[UART_MIRROR_EN_BIT]
                && uart_override_control[UART_TX_EN_BIT];
            o_uart_baud_slow <= unlocked && uart_override_control[UART_BAUD_BIT];
            serial_auto_driven <= !serial_user;
            chain_auto_driven <= !daisy_user;
        end
    end

    // command frame tracking
    assign frame_accepted = i_rx_event.byte_valid && !ignoring;

    always_comb begin
        error_event = '0;
        if (frame_accepted && i_rx_event.is_init_byte) begin
            error_event.init_byte_error = i_rx_event.stop_error
                || i_rx_event.frame_type_bad || i_rx_event.reserved_bit_set;
            if (!error_event.init_byte_error) begin
                error_event.read_while_tx_off = i_rx_event.is_read_command
                    && !o_uart_tx_enable;
                error_event.unexpected_command = i_rx_event.is_stack_or_broadcast
                    && i_stacked_role && !i_shared_bus_mode;
            end
        end
        if (frame_accepted && !i_rx_event.is_init_byte) begin
            error_event.frame_byte_error = i_rx_event.byte_error;
        end
        error_event.early_clear_error = i_rx_event.comm_clear && in_frame
            && !ignoring;
        // ignored frames raise nothing further
        error_event.command_crc_error = i_rx_event.frame_end && !ignoring
            && i_rx_event.crc_bad;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ignoring <= 1'b0;
            in_frame <= 1'b0;
        end else if (i_clk_en) begin
            if (i_rx_event.comm_clear) begin
                ignoring <= 1'b0;
                in_frame <= 1'b0;
            end else begin
                if (error_event.init_byte_error || error_event.frame_byte_error) begin
                    ignoring <= 1'b1;
                end
                if (i_rx_event.byte_valid && i_rx_event.is_init_byte) begin
                    in_frame <= 1'b1;
                end else if (i_rx_event.frame_end) begin
                    in_frame <= 1'b0;
                end
            end
        end
    end

    // frame counter strobes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_frame_valid <= 1'b0;
            o_frame_discard <= 1'b0;
        end else if (i_clk_en) begin
            o_frame_valid <= i_rx_event.frame_end && !ignoring && !i_rx_event.crc_bad;
            o_frame_discard <= error_event.command_crc_error;
        end
    end

    // sticky command errors, a new event beats the fault reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            uart_command_errors <= '0;
        end else if (i_clk_en) begin
            if (i_fault_reset) begin
                uart_command_errors <= error_event;
            end else begin
                uart_command_errors <= uart_command_errors | error_event;
            end
        end
    end

    // apb slave: one wait-free access, pready answers in the first access cycle
    assign setup_phase = i_psel && !i_penable && !o_pready;
    assign access_done = i_psel && i_penable && o_pready;
    assign write_done = access_done && i_pwrite && !o_pslverr && i_pstrb[0];
    assign word_index = {2'b00, i_paddr[ADDR_WIDTH-1:2]};

    always_comb begin
        addr_mapped = 1'b1;
        next_read_value = '0;
        if (i_paddr[1:0] != 2'b00) begin
            addr_mapped = 1'b0;
        end else if (word_index == DEBUG_UNLOCK_KEY_INDEX) begin
            next_read_value = debug_unlock_key;
        end else if (word_index == UART_OVERRIDE_CONTROL_INDEX) begin
            next_read_value = uart_override_control;
        end else if (word_index == DAISY_PORT_OVERRIDE_INDEX) begin
            next_read_value = daisy_port_override;
        end else if (word_index == PORT_DRIVER_STATUS_INDEX) begin
            next_read_value = {2'b00, serial_auto_driven, chain_auto_driven,
                o_port_enable};
        end else if (word_index == UART_COMMAND_ERRORS_INDEX) begin
            next_read_value = {2'b00, uart_command_errors};
        end else if (word_index == EVENT_STATUS_INDEX) begin
            next_read_value = {2'b00, event_status};
        end else if (word_index == EVENT_ENABLE_INDEX) begin
            next_read_value = {2'b00, event_enable};
        end else if (word_index == EVENT_CLEAR_INDEX) begin
            next_read_value = '0;
        end else begin
            addr_mapped = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else if (i_clk_en) begin
            o_pready <= setup_phase;
            o_pslverr <= setup_phase && !addr_mapped;
            if (setup_phase) begin
                o_prdata <= {{(DATA_WIDTH-REG_WIDTH){1'b0}}, next_read_value};
            end
        end
    end

    // software registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            debug_unlock_key <= DEBUG_UNLOCK_KEY_RESET;
            uart_override_control <= UART_OVERRIDE_CONTROL_RESET;
            daisy_port_override <= DAISY_PORT_OVERRIDE_RESET;
            event_enable <= EVENT_ENABLE_RESET[ERROR_COUNT-1:0];
        end else if (i_clk_en && write_done) begin
            if (word_index == DEBUG_UNLOCK_KEY_INDEX) begin
                debug_unlock_key <= i_pwdata[REG_WIDTH-1:0];
            end else if (word_index == UART_OVERRIDE_CONTROL_INDEX) begin
                uart_override_control <= {3'b000, i_pwdata[UART_BAUD_BIT:0]};
            end else if (word_index == DAISY_PORT_OVERRIDE_INDEX) begin
                daisy_port_override <= {4'h0, i_pwdata[PORT_FIELD_WIDTH-1:0]};
            end else if (word_index == EVENT_ENABLE_INDEX) begin
                event_enable <= i_pwdata[ERROR_COUNT-1:0];
            end
        end
    end

    // interrupt status: write one to clear, a new event wins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            event_status <= '0;
        end else if (i_clk_en) begin
            if (write_done && word_index == EVENT_CLEAR_INDEX) begin
                event_status <= (event_status & ~i_pwdata[ERROR_COUNT-1:0]) | error_event;
            end else begin
                event_status <= event_status | error_event;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_irq <= |(event_status & event_enable);
        end
    end

endmodule

// ==== tb/comm_debug_checker.sv ====
`timescale 1ns/1ps
module comm_debug_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [comm_debug_pkg::ADDR_WIDTH-1:0] i_paddr,
    input wire logic [comm_debug_pkg::DATA_WIDTH-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [comm_debug_pkg::DATA_WIDTH-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_stacked_role,
    input wire comm_debug_pkg::port_enable_type i_auto_port_enable,
    input wire comm_debug_pkg::uart_rx_event_type i_rx_event,
    input wire comm_debug_pkg::port_enable_type o_port_enable,
    input wire logic o_uart_tx_enable,
    input wire logic o_uart_mirror_enable,
    input wire logic o_uart_baud_slow,
    input wire logic o_frame_valid,
    input wire logic o_frame_discard
);
    import comm_debug_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_ready_after_setup;
        i_clk_en && i_psel && !i_penable |=> o_pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    property p_ready_single;
        i_clk_en && o_pready |=> !o_pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready longer than one cycle");
    property p_error_with_ready;
        o_pslverr |-> o_pready;
    endproperty
    a_error_with_ready: assert property (p_error_with_ready)
        else $error("slave error without ready");
    property p_read_upper_zero;
        o_pready |-> o_prdata[31:8] == 24'h0;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero)
        else $error("read data upper bits set");
    property p_mirror_needs_tx;
        o_uart_mirror_enable |-> o_uart_tx_enable;
    endproperty
    a_mirror_needs_tx: assert property (p_mirror_needs_tx)
        else $error("mirror without transmitter");
    property p_discard_cause;
        o_frame_discard |-> $past(i_rx_event.frame_end) && $past(i_rx_event.crc_bad);
    endproperty
    a_discard_cause: assert property (p_discard_cause)
        else $error("discard without failed frame end");
    property p_valid_cause;
        o_frame_valid |-> $past(i_rx_event.frame_end) && !$past(i_rx_event.crc_bad);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("valid without good frame end");
    property p_key_cancel;
        i_clk_en && i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
            && i_paddr == {DEBUG_UNLOCK_KEY_INDEX[13:0], 2'b00}
            && i_pwdata[7:0] != UNLOCK_CODE
        |=> ##1 o_port_enable == $past(i_auto_port_enable) && !o_uart_mirror_enable
            && !o_uart_baud_slow && o_uart_tx_enable == !$past(i_stacked_role);
    endproperty
    a_key_cancel: assert property (p_key_cancel)
        else $error("override still active after lock");
endmodule
bind comm_debug_override_status comm_debug_checker u_comm_debug_checker (
    .i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_stacked_role(i_stacked_role), .i_auto_port_enable(i_auto_port_enable),
    .i_rx_event(i_rx_event), .o_port_enable(o_port_enable),
    .o_uart_tx_enable(o_uart_tx_enable), .o_uart_mirror_enable(o_uart_mirror_enable),
    .o_uart_baud_slow(o_uart_baud_slow), .o_frame_valid(o_frame_valid),
    .o_frame_discard(o_frame_discard)
);

// ==== tb/uart_host_model.sv ====
`timescale 1ns/1ps
module uart_host_model (
    input wire logic i_clk,
    output comm_debug_pkg::uart_rx_event_type o_rx_event
);
    import comm_debug_pkg::*;
    initial o_rx_event = '0;
    // one decoded receiver event, then idle for a cycle
    task automatic send(input logic [10:0] ev);
        @(posedge i_clk);
        o_rx_event <= uart_rx_event_type'(ev);
        @(posedge i_clk);
        o_rx_event <= '0;
    endtask
    task automatic frame(input logic [10:0] first, input logic [10:0] mid,
        input logic [10:0] last);
        send(first);
        send(mid);
        send(last);
    endtask
endmodule

// ==== tb/test_comm_debug_override_status.sv ====
`timescale 1ns/1ps
module test_comm_debug_override_status;
    import comm_debug_pkg::*;
    logic i_clk, i_reset, i_clk_en, i_psel, i_penable, i_pwrite, i_fault_reset;
    logic [15:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdata;
    logic [3:0] i_pstrb;
    logic o_pready, o_pslverr, perr, i_stacked_role, i_shared_bus_mode, o_irq;
    logic o_uart_tx_enable, o_uart_mirror_enable, o_uart_baud_slow;
    logic o_frame_valid, o_frame_discard;
    port_enable_type i_auto_port_enable, o_port_enable;
    uart_rx_event_type rx_event;
    int n_mismatch, num_checks, n_valid, n_discard;
    comm_debug_override_status u_comm_debug_override_status (
        .i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_stacked_role(i_stacked_role), .i_shared_bus_mode(i_shared_bus_mode),
        .i_auto_port_enable(i_auto_port_enable), .i_fault_reset(i_fault_reset),
        .i_rx_event(rx_event), .o_port_enable(o_port_enable),
        .o_uart_tx_enable(o_uart_tx_enable), .o_uart_mirror_enable(o_uart_mirror_enable),
        .o_uart_baud_slow(o_uart_baud_slow), .o_frame_valid(o_frame_valid),
        .o_frame_discard(o_frame_discard), .o_irq(o_irq)
    );
    uart_host_model u_uart_host_model (.i_clk(i_clk), .o_rx_event(rx_event));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(negedge i_clk) begin
        n_valid += int'(o_frame_valid === 1'b1);
        n_discard += int'(o_frame_discard === 1'b1);
    end
    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int i;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {idx[13:0], 2'b00};
        i_pwdata <= {24'h0, wd};
        @(posedge i_clk);
        i_penable <= 1'b1;
        i = 0;
        // pready is judged at the rising edge, where the access completes
        @(posedge i_clk);
        while (o_pready !== 1'b1) begin
            i++;
            if (i > 16) begin
                n_mismatch++;
                report_and_stop;
            end
            @(posedge i_clk);
        end
        rdata = o_prdata;
        perr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdata, {24'h0, exp});
    endtask
    // ports, transmitter, mirror, baud after the outputs have taken the new setting
    task automatic outs(input logic [6:0] exp);
        @(posedge i_clk);
        @(negedge i_clk);
        chk({25'h0, o_port_enable, o_uart_tx_enable, o_uart_mirror_enable, o_uart_baud_slow},
            {25'h0, exp});
    endtask
    task automatic irq_is(input logic exp);
        @(posedge i_clk);
        @(negedge i_clk);
        chk({31'h0, o_irq}, {31'h0, exp});
    endtask
    task automatic reset_values;
        rd(DEBUG_UNLOCK_KEY_INDEX, 8'h00);
        rd(UART_OVERRIDE_CONTROL_INDEX, 8'h04);
        rd(DAISY_PORT_OVERRIDE_INDEX, 8'h0F);
        rd(PORT_DRIVER_STATUS_INDEX, 8'h33);
        rd(UART_COMMAND_ERRORS_INDEX, 8'h00);
        apb(1'b0, 16'h0703, 8'h00);
        chk({31'h0, perr}, 32'h1);
        chk(rdata, 32'h0);
    endtask
    task automatic override_cycle;
        apb(1'b1, UART_OVERRIDE_CONTROL_INDEX, 8'h1F);
        apb(1'b1, DAISY_PORT_OVERRIDE_INDEX, 8'h05);
        outs(7'b0011_100);
        apb(1'b1, DEBUG_UNLOCK_KEY_INDEX, UNLOCK_CODE);
        outs(7'b0101_111);
        rd(PORT_DRIVER_STATUS_INDEX, 8'h05);
        apb(1'b1, UART_OVERRIDE_CONTROL_INDEX, 8'h0A);
        outs(7'b0011_000);
        rd(PORT_DRIVER_STATUS_INDEX, 8'h13);
        apb(1'b1, UART_OVERRIDE_CONTROL_INDEX, 8'h1D);
        outs(7'b0101_101);
        apb(1'b1, DEBUG_UNLOCK_KEY_INDEX, 8'h5A);
        outs(7'b0011_100);
        rd(PORT_DRIVER_STATUS_INDEX, 8'h33);
    endtask
    task automatic command_errors;
        u_uart_host_model.frame(11'h600, 11'h400, 11'h004);
        u_uart_host_model.frame(11'h600, 11'h400, 11'h006);
        u_uart_host_model.frame(11'h700, 11'h400, 11'h004);
        u_uart_host_model.send(11'h001);
        u_uart_host_model.frame(11'h600, 11'h420, 11'h004);
        u_uart_host_model.send(11'h001);
        chk(32'(n_valid), 32'h1);
        chk(32'(n_discard), 32'h1);
        u_uart_host_model.send(11'h600);
        u_uart_host_model.send(11'h001);
        @(posedge i_clk);
        i_stacked_role <= 1'b1;
        outs(7'b0011_000);
        u_uart_host_model.frame(11'h618, 11'h400, 11'h004);
        rd(UART_COMMAND_ERRORS_INDEX, 8'h3F);
        rd(UART_COMMAND_ERRORS_INDEX, 8'h3F);
        @(posedge i_clk);
        i_fault_reset <= 1'b1;
        @(posedge i_clk);
        i_fault_reset <= 1'b0;
        rd(UART_COMMAND_ERRORS_INDEX, 8'h00);
        i_shared_bus_mode <= 1'b1;
        u_uart_host_model.frame(11'h618, 11'h400, 11'h004);
        rd(UART_COMMAND_ERRORS_INDEX, 8'h10);
    endtask
    task automatic irq_path;
        apb(1'b1, EVENT_ENABLE_INDEX, 8'h01);
        irq_is(1'b1);
        apb(1'b1, EVENT_ENABLE_INDEX, 8'h00);
        irq_is(1'b0);
        apb(1'b1, EVENT_ENABLE_INDEX, 8'h01);
        rd(EVENT_STATUS_INDEX, 8'h3F);
        apb(1'b1, EVENT_CLEAR_INDEX, 8'h3F);
        irq_is(1'b0);
        rd(EVENT_STATUS_INDEX, 8'h00);
    endtask
    initial begin
        {i_reset, i_clk_en} = 2'b11;
        {i_psel, i_penable, i_pwrite, i_fault_reset} = 4'h0;
        {i_stacked_role, i_shared_bus_mode} = 2'b00;
        {i_paddr, i_pwdata, i_pstrb} = {16'h0, 32'h0, 4'hF};
        i_auto_port_enable = port_enable_type'(4'h3);
        {n_mismatch, num_checks, n_valid, n_discard} = '0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        reset_values;
        override_cycle;
        command_errors;
        irq_path;
        report_and_stop;
    end
endmodule
